// [common/rmc_cfg.svh]
// Constants for the registered magnitude comparator
`ifndef RMC_CFG_SVH
`define RMC_CFG_SVH

// ============================================================
// Word and mode codes
`define RMC_WORD_W        8
`define RMC_MODE_HOLD     2'h0
`define RMC_MODE_SHIFT    2'h1
`define RMC_MODE_LOAD     2'h3
`define RMC_MODE_DRIVE    2'h2

// ============================================================
// Reset, idle and active levels
`define RMC_STATUS_OFF    1'h1
`define RMC_STATUS_ON     1'h0
`define RMC_OE_N_RELEASE  1'h1
`define RMC_OE_N_DRIVE    1'h0
`define RMC_LINK_RESET    1'h0

// ============================================================
// Positions in the synchronised pin vector
`define RMC_PIN_GATE      0
`define RMC_PIN_LINK      1
`define RMC_PIN_SIGNED    2
`define RMC_PIN_SEL_LO    3
`define RMC_PIN_SEL_HI    4
`define RMC_PIN_DATA_LO   5

`endif

// [common/rmc_pkg.sv]
// Types shared by the registered magnitude comparator
`include "rmc_cfg.svh"

package rmc_pkg;

    // Gray order along hold, shift, load, drive
    typedef enum logic [1:0] {
        RMC_HOLD  = `RMC_MODE_HOLD,
        RMC_SHIFT = `RMC_MODE_SHIFT,
        RMC_DRIVE = `RMC_MODE_DRIVE,
        RMC_LOAD  = `RMC_MODE_LOAD
    } rmc_mode_t;

endpackage : rmc_pkg

// [core/rmc_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
module rmc_pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Pins and filtered result
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);
    wire  [WIDTH-1:0] next_level = (stage2 & agree) | (level & ~agree);

    if (WIDTH < 1) begin : g_width_check
        $error("rmc_pin_sync: WIDTH must be at least 1");
    end

    // Stage 1 feeds only stage 2
    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level  <= '0;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
        end
    end

endmodule // rmc_pin_sync

// [core/rmc_comparator.sv]
// Registered magnitude comparator with shared parallel pins and serial link
// ============================================================
`include "rmc_cfg.svh"
module rmc_comparator
    import rmc_pkg::*;
#(
    parameter int WIDTH = `RMC_WORD_W
) (
    // Clock and reset
    input  wire logic             SYS_CLK,
    input  wire logic             RST,
    // Shared parallel pins
    input  wire logic [WIDTH-1:0] DATA_IN,
    output logic      [WIDTH-1:0] DATA_OUT,
    output logic                  DATA_OE_N,
    // Mode selection
    input  wire logic             SELECT_LOW,
    input  wire logic             SELECT_HIGH,
    input  wire logic             SIGNED_MODE,
    // Serial link and priority chain
    input  wire logic             LINK_IN,
    output logic                  LINK_OUT,
    // Status
    input  wire logic             STATUS_OUTPUT_GATE,
    output logic                  STATUS_ABOVE,
    output logic                  STATUS_BELOW,
    output logic                  STATUS_MATCH
);

    localparam int SYNC_W = WIDTH + `RMC_PIN_DATA_LO;

    if (WIDTH < 2) begin : g_width_check
        $error("rmc_comparator: WIDTH must be at least 2");
    end

    // ============================================================
    // Pin synchronisation
    // Data and controls share one path, so a mode and the bus value
    // it acts on arrive together; the cost is four edges of latency.
    logic [SYNC_W-1:0] pins_q;
    logic [WIDTH-1:0]  word;

    rmc_pin_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk   (SYS_CLK),
        .rst   (RST),
        .pin   ({DATA_IN, SELECT_HIGH, SELECT_LOW, SIGNED_MODE, LINK_IN, STATUS_OUTPUT_GATE}),
        .level (pins_q)
    );

    wire [WIDTH-1:0] bus_q    = pins_q[SYNC_W-1:`RMC_PIN_DATA_LO];
    wire [1:0]       sel_q    = pins_q[`RMC_PIN_SEL_HI:`RMC_PIN_SEL_LO];
    wire             signed_q = pins_q[`RMC_PIN_SIGNED];
    wire             link_q   = pins_q[`RMC_PIN_LINK];
    wire             gate_q   = pins_q[`RMC_PIN_GATE];

    // ============================================================
    // Mode decode
    wire rmc_mode_t  mode     = rmc_mode_t'(sel_q);
    wire             is_shift = (mode == RMC_SHIFT);
    wire             is_load  = (mode == RMC_LOAD);
    wire             is_drive = (mode == RMC_DRIVE);

    // ============================================================
    // Comparator
    // Flipping both MSBs turns two's complement order into unsigned order
    function automatic logic [WIDTH-1:0] bias(input logic [WIDTH-1:0] v, input logic sgn);
        bias = {v[WIDTH-1] ^ sgn, v[WIDTH-2:0]};
    endfunction

    wire [WIDTH-1:0] op_reg   = bias(word, signed_q);
    wire [WIDTH-1:0] op_bus   = bias(bus_q, signed_q);
    wire             cmp_gt   = op_reg > op_bus;
    wire             cmp_lt   = op_reg < op_bus;
    wire             cmp_eq   = op_reg == op_bus;

    // Only the package where the word first differs drives a result;
    // all others release, so the wired-AND settles on its answer.
    wire             decides  = link_q & ~cmp_eq & ~is_shift & ~gate_q;
    wire             next_above = decides ? (cmp_gt ? `RMC_STATUS_OFF : `RMC_STATUS_ON) : `RMC_STATUS_OFF;
    wire             next_below = decides ? (cmp_lt ? `RMC_STATUS_OFF : `RMC_STATUS_ON) : `RMC_STATUS_OFF;
    wire             next_match = decides ? `RMC_STATUS_ON : `RMC_STATUS_OFF;

    // ============================================================
    // Register and link
    // Status and link leave from flops so the wired-AND sees clean edges.
    wire [WIDTH-1:0] next_word = is_load  ? bus_q :
                                 is_shift ? {link_q, word[WIDTH-1:1]} : word;
    wire             next_link = is_shift ? word[0] : (link_q & cmp_eq);

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            word         <= '0;
            DATA_OUT     <= '0;
            DATA_OE_N    <= `RMC_OE_N_RELEASE;
            LINK_OUT     <= `RMC_LINK_RESET;
            STATUS_ABOVE <= `RMC_STATUS_OFF;
            STATUS_BELOW <= `RMC_STATUS_OFF;
            STATUS_MATCH <= `RMC_STATUS_OFF;
        end else begin
            word         <= next_word;
            DATA_OUT     <= word;
            DATA_OE_N    <= is_drive ? `RMC_OE_N_DRIVE : `RMC_OE_N_RELEASE;
            LINK_OUT     <= next_link;
            STATUS_ABOVE <= next_above;
            STATUS_BELOW <= next_below;
            STATUS_MATCH <= next_match;
        end
    end

    // ============================================================
    // Assertions
    // Checks read the filtered pins, so they line up with the register edge.
    property p_gate_off;
        @(posedge SYS_CLK) disable iff (RST)
        gate_q |=> (STATUS_ABOVE && STATUS_BELOW && STATUS_MATCH);
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("status not off while gated");

    property p_load;
        @(posedge SYS_CLK) disable iff (RST)
        is_load |=> (word == $past(bus_q));
    endproperty
    a_load: assert property (p_load) else $error("load did not capture bus");

    property p_hold;
        @(posedge SYS_CLK) disable iff (RST)
        (mode == RMC_HOLD) |=> $stable(word);
    endproperty
    a_hold: assert property (p_hold) else $error("hold changed the word");

    property p_shift;
        @(posedge SYS_CLK) disable iff (RST)
        is_shift |=> (word == {$past(link_q), $past(word[WIDTH-1:1])}) && (LINK_OUT == $past(word[0]));
    endproperty
    a_shift: assert property (p_shift) else $error("shift order wrong");

    property p_drive;
        @(posedge SYS_CLK) disable iff (RST)
        is_drive ##1 is_drive |=> (DATA_OE_N == `RMC_OE_N_DRIVE) && (DATA_OUT == $past(word, 2));
    endproperty
    a_drive: assert property (p_drive) else $error("drive mode not on pins");

    property p_one_result;
        @(posedge SYS_CLK) disable iff (RST)
        decides |=> !STATUS_MATCH && $onehot({STATUS_ABOVE, STATUS_BELOW});
    endproperty
    a_one_result: assert property (p_one_result) else $error("not exactly one result");

    property p_priority;
        @(posedge SYS_CLK) disable iff (RST)
        (!link_q || is_shift) |=> (STATUS_ABOVE && STATUS_BELOW && STATUS_MATCH);
    endproperty
    a_priority: assert property (p_priority) else $error("lesser package drove status");

    property p_chain;
        @(posedge SYS_CLK) disable iff (RST)
        !is_shift |=> (LINK_OUT == ($past(link_q) && $past(word) == $past(bus_q)));
    endproperty
    a_chain: assert property (p_chain) else $error("priority chain wrong");

    property p_signed;
        @(posedge SYS_CLK) disable iff (RST)
        (signed_q && link_q && !gate_q && !is_shift && word[WIDTH-1] != bus_q[WIDTH-1])
            |=> (STATUS_ABOVE == $past(bus_q[WIDTH-1]));
    endproperty
    a_signed: assert property (p_signed) else $error("signed order wrong");

    property p_reset;
        @(posedge SYS_CLK)
        RST |=> (word == '0) && (DATA_OE_N == `RMC_OE_N_RELEASE) && (LINK_OUT == `RMC_LINK_RESET)
            && STATUS_ABOVE && STATUS_BELOW && STATUS_MATCH;
    endproperty
    a_reset: assert property (p_reset) else $error("reset values wrong");

    property p_match_low;
        @(posedge SYS_CLK) disable iff (RST)
        !STATUS_MATCH |-> (STATUS_ABOVE != STATUS_BELOW);
    endproperty
    a_match_low: assert property (p_match_low) else $error("match driven without a single result");

    // Order checks use plain and signed compares, not the biased operands
    property p_unsigned;
        @(posedge SYS_CLK) disable iff (RST)
        (decides && !signed_q) |=> (STATUS_ABOVE == ($past(word) > $past(bus_q)));
    endproperty
    a_unsigned: assert property (p_unsigned) else $error("unsigned order wrong");

    property p_signed_below;
        @(posedge SYS_CLK) disable iff (RST)
        (decides && signed_q) |=> (STATUS_BELOW == ($signed($past(word)) < $signed($past(bus_q))));
    endproperty
    a_signed_below: assert property (p_signed_below) else $error("signed below wrong");

    property p_equal_release;
        @(posedge SYS_CLK) disable iff (RST)
        (link_q && !is_shift && (word == bus_q)) |=> (STATUS_ABOVE && STATUS_BELOW && STATUS_MATCH && LINK_OUT);
    endproperty
    a_equal_release: assert property (p_equal_release) else $error("equal package did not pass on");

    property p_oe_release;
        @(posedge SYS_CLK) disable iff (RST)
        !is_drive |=> (DATA_OE_N == `RMC_OE_N_RELEASE);
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("bus driven outside drive mode");

    property p_chain_low;
        @(posedge SYS_CLK) disable iff (RST)
        (!link_q && !is_shift) |=> !LINK_OUT;
    endproperty
    a_chain_low: assert property (p_chain_low) else $error("link passed on below a difference");

endmodule // rmc_comparator

// [test/rmc_bus_model.sv]
// Far side of the shared parallel pins: another bus party
module rmc_bus_model (
    // Device pins
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe_n,
    input  wire logic       link_out,
    input  wire logic [2:0] status,
    // Value the other party offers
    input  wire logic [7:0] host_val,
    input  wire logic [2:0] lower_status,
    output logic      [7:0] data_in,
    output logic      [2:0] status_bus
);
    timeunit 1ns;
    timeprecision 1ns;
    // The other party releases the bus while the device drives it
    assign data_in = data_oe_n ? host_val : data_out;
    // Board wired-AND with a lesser package that may only drive while the link says equal
    assign status_bus = status & (link_out ? lower_status : 3'h7);
endmodule // rmc_bus_model

// [test/testbench.sv]
// Self-checking bench for the registered magnitude comparator
module testbench import rmc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, sgn, link, gate, oe_n, link_out, s_a, s_b, s_m;
    rmc_mode_t   mode;
    logic [7:0]  host_val, data_in, data_out, w, v, b;
    logic [15:0] exp_q[$];
    logic [15:0] e;
    logic [2:0]  low_st, low_pick, s_bus;
    logic [31:0] r;
    int          fail_count, total_checks, seed;
    event        look;
    rmc_bus_model rmc_bus_model_i (.data_out(data_out), .data_oe_n(oe_n), .link_out(link_out),
        .status({s_a, s_b, s_m}), .host_val(host_val), .lower_status(low_st),
        .data_in(data_in), .status_bus(s_bus));
    rmc_comparator rmc_comparator_i (.SYS_CLK(clk), .RST(rst), .DATA_IN(data_in), .DATA_OUT(data_out),
        .DATA_OE_N(oe_n), .SELECT_LOW(mode[0]), .SELECT_HIGH(mode[1]), .SIGNED_MODE(sgn), .LINK_IN(link),
        .LINK_OUT(link_out), .STATUS_OUTPUT_GATE(gate), .STATUS_ABOVE(s_a), .STATUS_BELOW(s_b), .STATUS_MATCH(s_m));
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    task check(string nm, logic [7:0] seen, logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Returns above, below, match, link out; equal or released packages leave all status off
    function logic [3:0] exp_st(logic [7:0] wv, logic [7:0] bv, logic s, logic l, logic g, logic sh);
        logic [7:0] x, y;
        x = wv ^ {s, 7'h00};
        y = bv ^ {s, 7'h00};
        if (g || !l || sh || x == y) exp_st = {3'h7, sh ? wv[0] : (l && x == y)};
        else exp_st = {x > y, x < y, 2'h0};
    endfunction
    // Inputs land 1 ns after the edge; 12 cycles cover the pin filter and a bus turnaround
    task apply(rmc_mode_t m, logic [7:0] hv, logic s, logic l, logic g);
        @(posedge clk);
        #1 mode = m;
        {host_val, sgn, link, gate} = {hv, s, l, g};
        // The lesser package offers a result only while the device holds
        low_st = (m == RMC_HOLD) ? low_pick : 3'h7;
        repeat (12) @(posedge clk);
        #1;
    endtask
    task look_at(logic sh);
        logic [3:0] s;
        s = exp_st(w, (mode == RMC_DRIVE) ? w : host_val, sgn, link, gate, sh);
        exp_q.push_back({s[3:1] & (s[0] ? low_st : 3'h7), s, mode != RMC_DRIVE, w});
        ->look;
    endtask
    initial begin
        forever begin
            @(look);
            while (exp_q.size() > 0) begin
                e = exp_q.pop_front();
                check("status", 8'({s_a, s_b, s_m}), 8'(e[12:10]));
                check("wired", 8'(s_bus), 8'(e[15:13]));
                check("link_out", 8'(link_out), 8'(e[9]));
                check("oe_n", 8'(oe_n), 8'(e[8]));
                if (e[8] === 1'h0) check("data_out", data_out, e[7:0]);
            end
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        wrap_up;
    end
    initial begin
        {rst, host_val, sgn, link, gate, w} = {1'h1, 8'h00, 1'h0, 1'h1, 1'h0, 8'h00};
        mode = RMC_HOLD;
        {low_st, low_pick} = {3'h7, 3'h7};
        {fail_count, total_checks, seed} = {32'h0, 32'h0, 32'h4ce5};
        repeat (8) @(posedge clk);
        #1 rst = 1'h0;
        exp_q.push_back({3'h7, 3'h7, 1'h0, 1'h1, 8'h00});
        ->look;
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            {v, b} = r[15:0];
            low_pick = {r[21], ~r[21], 1'h0};
            if (i % 5 == 0) b = v;
            if (i < 6) begin
                {v, b} = (i < 2) ? 16'h807f : (i < 4) ? 16'h00ff : 16'h7f80;
                r[20:16] = {4'h2, i[0]};
            end
            apply(RMC_LOAD, v, 1'h0, 1'h1, 1'h0);
            w = v;
            look_at(1'h0);
            apply(RMC_HOLD, b, r[16], |r[18:17], &r[20:19]);
            look_at(1'h0);
            if (i % 4 == 0) begin
                apply(RMC_DRIVE, b, r[16], 1'h1, 1'h0);
                look_at(1'h0);
            end
        end
        // Short shift into a cleared word: ones must enter at the top
        apply(RMC_LOAD, 8'h00, 1'h0, 1'h1, 1'h0);
        @(posedge clk);
        #1 mode = RMC_SHIFT;
        repeat (3) @(posedge clk);
        #1 mode = RMC_HOLD;
        apply(RMC_DRIVE, 8'h00, 1'h0, 1'h1, 1'h0);
        check("shift_dir", 8'({data_out[7], data_out[0]}), 8'h02);
        for (int k = 0; k < 2; k++) begin
            apply(RMC_SHIFT, 8'h5a, 1'h0, !k[0], 1'h0);
            apply(RMC_SHIFT, 8'h5a, 1'h0, !k[0], 1'h0);
            w = k[0] ? 8'h00 : 8'hff;
            look_at(1'h1);
            apply(RMC_DRIVE, 8'h5a, 1'h0, 1'h1, 1'h0);
            look_at(1'h0);
        end
        @(posedge clk);
        wrap_up;
    end
endmodule // testbench
